// File: design/twpd_decoder.v
// Touch widget decoder: per-sensor samples in, button, keypad, slider,
// trackpad and proximity results out, refreshed once per complete scan.
// Assumes the front end presents one sample per cycle from the mclk domain.
`include "twpd_consts.vh"

module twpd_decoder (
   input wire mclk,               // System clock, 100 MHz.
   input wire rstn,               // Asynchronous reset, active low.
   input wire smp_valid,          // Sample present this cycle.
   output wire smp_ready,         // Block accepts a sample this cycle.
   input wire [5:0] smp_idx,      // Sensor channel of the sample.
   input wire [15:0] smp_raw,     // Measured count.
   input wire [15:0] smp_base,    // Baseline count.
   input wire smp_last,           // Sample closes the scan.
   input wire [15:0] cfg_fthr,    // Finger threshold on signal.
   input wire [15:0] cfg_noise,   // Noise floor for the centroid.
   input wire [15:0] cfg_res,     // Slider resolution.
   input wire [15:0] cfg_pthr,    // Proximity threshold.
   input wire cfg_pgang,          // Proximity from ganged button sensors.
   output reg [3:0] btn_on,       // Simple button states.
   output reg key_valid,          // One key resolved.
   output reg [3:0] key_idx,      // Resolved key index.
   output reg key_invalid,        // Multi-touch on the keypad.
   output reg [15:0] lin_pos,     // Linear slider position.
   output reg lin_act,            // Linear slider touched.
   output reg [15:0] dip_pos,     // Diplexed slider position.
   output reg dip_act,            // Diplexed slider touched.
   output reg [15:0] rad_pos,     // Radial slider position.
   output reg rad_act,            // Radial slider touched.
   output reg [15:0] trk_x,       // Trackpad X position.
   output reg [15:0] trk_y,       // Trackpad Y position.
   output reg trk_act,            // Trackpad touched.
   output reg prox_on,            // Object approaching.
   output reg res_valid           // New results, one cycle.
);

   reg [15:0] sig_q [0:`TWPD_NCH-1];
   reg [2:0] st_q;
   reg [2:0] job_q;
   reg [15:0] pos_w_q [0:4];
   reg [4:0] act_w_q;

   reg [15:0] sv [0:15];
   reg [4:0] nseg;
   reg ring;
   reg [3:0] lo;
   reg [3:0] hi;
   reg [16:0] lo_b;
   reg [16:0] hi_b;
   reg [16:0] pr;
   reg [15:0] pk;
   reg [3:0] x;
   reg [15:0] sl;
   reg [15:0] sc;
   reg [15:0] sr;
   reg [47:0] sum;
   reg [47:0] num;
   reg [47:0] den;
   reg [47:0] q;
   reg [15:0] pos_c;
   reg act_c;
   integer k;

   reg [3:0] rowv;
   reg [2:0] colv;
   reg [2:0] nrow;
   reg [1:0] ncol;
   reg [1:0] rsel;
   reg [1:0] csel;
   reg [17:0] gang;
   integer i;

   wire [15:0] smp_diff;

   assign smp_ready = (st_q == `TWPD_ST_SCAN);
   assign smp_diff = (smp_raw > smp_base) ? smp_raw - smp_base : 16'h0000;

   function [15:0] nsub;
      input [15:0] s;
      input [15:0] t;
      begin
         nsub = (s > t) ? s - t : 16'h0000;
      end
   endfunction

   // Second-half wiring of the diplexed slider: neighbours sit three channels apart.
   function [2:0] dperm;
      input [2:0] j;
      begin
         case (j)
            3'h0: dperm = 3'h0;
            3'h1: dperm = 3'h3;
            3'h2: dperm = 3'h6;
            3'h3: dperm = 3'h1;
            3'h4: dperm = 3'h4;
            3'h5: dperm = 3'h7;
            3'h6: dperm = 3'h2;
            default: dperm = 3'h5;
         endcase
      end
   endfunction

   // Slider centroid for the job under way, one slider per cycle.
   always @* begin
      nseg = `TWPD_N_LIN;
      ring = 1'b0;
      for (k = 0; k < 16; k = k + 1) begin
         sv[k] = 16'h0000;
      end
      case (job_q)
         `TWPD_J_LIN: begin
            for (k = 0; k < 5; k = k + 1) begin
               sv[k] = sig_q[`TWPD_CH_LIN + k];
            end
         end
         `TWPD_J_DIP: begin
            nseg = `TWPD_N_DIP;
            for (k = 0; k < 8; k = k + 1) begin
               sv[k] = sig_q[`TWPD_CH_DIP + k];
               sv[k + 8] = sig_q[`TWPD_CH_DIP + dperm(k[2:0])];
            end
         end
         `TWPD_J_RAD: begin
            nseg = `TWPD_N_RAD;
            ring = 1'b1;
            for (k = 0; k < 8; k = k + 1) begin
               sv[k] = sig_q[`TWPD_CH_RAD + k];
            end
         end
         `TWPD_J_TX: begin
            nseg = `TWPD_N_TRK;
            for (k = 0; k < 5; k = k + 1) begin
               sv[k] = sig_q[`TWPD_CH_TX + k];
            end
         end
         `TWPD_J_TY: begin
            nseg = `TWPD_N_TRK;
            for (k = 0; k < 5; k = k + 1) begin
               sv[k] = sig_q[`TWPD_CH_TY + k];
            end
         end
         default: nseg = `TWPD_N_LIN;
      endcase
      lo = 4'h0;
      hi = nseg[3:0] - 4'h1;
      // Aliased touches scatter, so the real half shows the strongest pair.
      lo_b = 17'h0_0000;
      hi_b = 17'h0_0000;
      pr = 17'h0_0000;
      if (nseg == `TWPD_N_DIP) begin
         for (k = 0; k < 7; k = k + 1) begin
            pr = {1'b0, sv[k]} + {1'b0, sv[k + 1]};
            if (pr > lo_b) lo_b = pr;
            pr = {1'b0, sv[k + 8]} + {1'b0, sv[k + 9]};
            if (pr > hi_b) hi_b = pr;
         end
         if (lo_b >= hi_b) begin
            hi = 4'h7;
         end else begin
            lo = 4'h8;
         end
      end
      pk = 16'h0000;
      x = lo;
      for (k = 0; k < 16; k = k + 1) begin
         if (k >= lo && k <= hi && sv[k] > pk) begin
            pk = sv[k];
            x = k[3:0];
         end
      end
      // Only the peak and its two neighbours enter the centroid.
      if (x == 4'h0) begin
         sl = ring ? sv[nseg[3:0] - 4'h1] : 16'h0000;
      end else begin
         sl = sv[x - 4'h1];
      end
      if (x == hi && !ring && nseg != `TWPD_N_DIP) begin
         sr = 16'h0000;
      end else if (x == nseg[3:0] - 4'h1) begin
         sr = ring ? sv[0] : 16'h0000;
      end else begin
         sr = sv[x + 4'h1];
      end
      sl = nsub(sl, cfg_noise);
      sc = nsub(pk, cfg_noise);
      sr = nsub(sr, cfg_noise);
      sum = {32'h0000_0000, sl} + {32'h0000_0000, sc} + {32'h0000_0000, sr};
      num = {44'h000_0000_0000, x} * sum + {32'h0000_0000, sr};
      if (num >= {32'h0000_0000, sl}) begin
         num = num - {32'h0000_0000, sl};
      end else begin
         num = num + {43'h000_0000_0000, nseg} * sum - {32'h0000_0000, sl};
      end
      if (ring) begin
         den = {43'h000_0000_0000, nseg} * sum;
      end else begin
         den = {43'h000_0000_0000, nseg - 5'h01} * sum;
      end
      q = 48'h0000_0000_0000;
      if (sum != 48'h0000_0000_0000) begin
         q = (num * {32'h0000_0000, cfg_res} + (den >> 1)) / den;
      end
      if (ring && q >= {32'h0000_0000, cfg_res}) begin
         q = 48'h0000_0000_0000;
      end
      pos_c = q[15:0];
      act_c = (pk >= cfg_fthr) && (sum != 48'h0000_0000_0000);
   end

   // Keypad and proximity decode from the stored scan.
   always @* begin
      nrow = 3'h0;
      ncol = 2'h0;
      rsel = 2'h0;
      csel = 2'h0;
      gang = 18'h0_0000;
      for (i = 0; i < `TWPD_N_ROW; i = i + 1) begin
         rowv[i] = (sig_q[`TWPD_CH_ROW + i] >= cfg_fthr);
         if (rowv[i]) begin
            nrow = nrow + 3'h1;
            rsel = i[1:0];
         end
      end
      for (i = 0; i < `TWPD_N_COL; i = i + 1) begin
         colv[i] = (sig_q[`TWPD_CH_COL + i] >= cfg_fthr);
         if (colv[i]) begin
            ncol = ncol + 2'h1;
            csel = i[1:0];
         end
      end
      for (i = 0; i < `TWPD_N_BTN; i = i + 1) begin
         gang = gang + {2'h0, sig_q[`TWPD_CH_BTN + i]};
      end
   end

   always @(posedge mclk) begin
      if (smp_valid && smp_ready && smp_idx < `TWPD_NCH) begin
         sig_q[smp_idx] <= smp_diff;
      end
      if (st_q == `TWPD_ST_CALC) begin
         pos_w_q[job_q] <= pos_c;
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q <= `TWPD_ST_SCAN;
         job_q <= `TWPD_J_LIN;
         act_w_q <= 5'h00;
         btn_on <= 4'h0;
         key_valid <= 1'b0;
         key_idx <= 4'h0;
         key_invalid <= 1'b0;
         lin_pos <= 16'h0000;
         lin_act <= 1'b0;
         dip_pos <= 16'h0000;
         dip_act <= 1'b0;
         rad_pos <= 16'h0000;
         rad_act <= 1'b0;
         trk_x <= 16'h0000;
         trk_y <= 16'h0000;
         trk_act <= 1'b0;
         prox_on <= 1'b0;
         res_valid <= 1'b0;
      end else begin
         res_valid <= 1'b0;
         case (st_q)
            `TWPD_ST_SCAN: begin
               if (smp_valid && smp_last) begin
                  st_q <= `TWPD_ST_CALC;
                  job_q <= `TWPD_J_LIN;
               end
            end
            `TWPD_ST_CALC: begin
               act_w_q[job_q] <= act_c;
               if (job_q == `TWPD_J_TY) begin
                  st_q <= `TWPD_ST_DONE;
               end else begin
                  job_q <= job_q + 3'h1;
               end
            end
            `TWPD_ST_DONE: begin
               // All widgets publish together so software never sees a mixed scan.
               for (i = 0; i < `TWPD_N_BTN; i = i + 1) begin
                  btn_on[i] <= (sig_q[`TWPD_CH_BTN + i] >= cfg_fthr);
               end
               key_valid <= (nrow == 3'h1) && (ncol == 2'h1);
               key_invalid <= (nrow > 3'h1) || (ncol > 2'h1);
               if (nrow == 3'h1 && ncol == 2'h1) begin
                  key_idx <= {rsel, 2'h0} - {2'h0, rsel} + {2'h0, csel};
               end else begin
                  key_idx <= 4'h0;
               end
               lin_pos <= pos_w_q[`TWPD_J_LIN];
               lin_act <= act_w_q[`TWPD_J_LIN];
               dip_pos <= pos_w_q[`TWPD_J_DIP];
               dip_act <= act_w_q[`TWPD_J_DIP];
               rad_pos <= pos_w_q[`TWPD_J_RAD];
               rad_act <= act_w_q[`TWPD_J_RAD];
               trk_x <= pos_w_q[`TWPD_J_TX];
               trk_y <= pos_w_q[`TWPD_J_TY];
               trk_act <= act_w_q[`TWPD_J_TX] && act_w_q[`TWPD_J_TY];
               if (cfg_pgang) begin
                  prox_on <= (gang >= {2'h0, cfg_pthr});
               end else begin
                  prox_on <= (sig_q[`TWPD_CH_PRX] >= cfg_pthr);
               end
               res_valid <= 1'b1;
               st_q <= `TWPD_ST_SCAN;
               job_q <= `TWPD_J_LIN;
            end
            default: begin
               st_q <= `TWPD_ST_SCAN;
            end
         endcase
      end
   end

endmodule

// File: common/twpd_consts.vh
// Constants for the touch widget position decoder: channel map, sizes and states.
// Assumes it is included once per design file by its bare name.
`ifndef TWPD_CONSTS_VH
`define TWPD_CONSTS_VH
`define TWPD_NCH 43
`define TWPD_CH_BTN 0
`define TWPD_CH_ROW 4
`define TWPD_CH_COL 8
`define TWPD_CH_LIN 11
`define TWPD_CH_DIP 16
`define TWPD_CH_RAD 24
`define TWPD_CH_TX 32
`define TWPD_CH_TY 37
`define TWPD_CH_PRX 42
`define TWPD_N_BTN 4
`define TWPD_N_ROW 4
`define TWPD_N_COL 3
`define TWPD_N_LIN 5'h05
`define TWPD_N_DIP 5'h10
`define TWPD_N_RAD 5'h08
`define TWPD_N_TRK 5'h05
`define TWPD_ST_SCAN 3'h1
`define TWPD_ST_CALC 3'h2
`define TWPD_ST_DONE 3'h4
`define TWPD_J_LIN 3'h0
`define TWPD_J_DIP 3'h1
`define TWPD_J_RAD 3'h2
`define TWPD_J_TX 3'h3
`define TWPD_J_TY 3'h4
`endif

// File: testbench/twpd_props.sv
// Checker for the decoder's result timing, hold and keypad outputs.
// Assumes it is bound to twpd_decoder and sees only that module's ports.
module twpd_props (
   input wire mclk, // Clock.
   input wire rstn, // Reset, active low.
   input wire smp_valid, // Sample present.
   input wire smp_ready, // Sample accepted.
   input wire smp_last, // Scan end.
   input wire [15:0] cfg_res, // Resolution.
   input wire [3:0] btn_on, // Buttons.
   input wire key_valid, // Key found.
   input wire [3:0] key_idx, // Key index.
   input wire key_invalid, // Multi-touch.
   input wire [15:0] lin_pos, // Linear position.
   input wire [15:0] trk_x, // X position.
   input wire res_valid // Result strobe.
);
   timeunit 1ns;
   timeprecision 1ps;
   wire tl;
   assign tl = smp_valid & smp_ready & smp_last;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_took;
      tl;
   endsequence
   sequence s_calc;
      !smp_ready [*6] ##1 smp_ready;
   endsequence
   chk_result_latency: assert property (s_took |-> ##7 res_valid)
      else $error("res_valid not seven cycles after scan end");
   chk_result_cause: assert property (res_valid |-> $past(tl, 7))
      else $error("res_valid without a scan end");
   chk_pulse_single: assert property (res_valid |=> !res_valid)
      else $error("res_valid longer than one cycle");
   chk_ready_blocked: assert property (s_took |=> s_calc)
      else $error("smp_ready wrong during calculation");
   chk_outputs_hold: assert property (!res_valid |->
      $stable({btn_on, key_valid, key_idx, key_invalid, lin_pos, trk_x}))
      else $error("result changed outside res_valid");
   chk_key_exclusive: assert property (key_valid |-> !key_invalid)
      else $error("key valid and invalid together");
   chk_key_noidx: assert property (key_invalid |-> key_idx == 4'h0 && !key_valid)
      else $error("invalid keypad reports a key");
   chk_key_range: assert property (key_valid |-> key_idx <= 4'hb)
      else $error("key index beyond row times column");
   chk_pos_range: assert property (res_valid |-> lin_pos <= cfg_res)
      else $error("linear position beyond resolution");
endmodule
bind twpd_decoder twpd_props chk_u (.mclk(mclk), .rstn(rstn), .smp_valid(smp_valid),
   .smp_ready(smp_ready), .smp_last(smp_last), .cfg_res(cfg_res), .btn_on(btn_on),
   .key_valid(key_valid), .key_idx(key_idx), .key_invalid(key_invalid),
   .lin_pos(lin_pos), .trk_x(trk_x), .res_valid(res_valid));

// File: testbench/twpd_frontend.sv
// Front-end model: one sample per channel per scan, baseline plus signal.
// Assumes the decoder's smp_ready settles before the falling edge.
module twpd_frontend (
   input wire mclk, // Clock.
   input wire smp_ready, // Decoder accepts.
   output logic smp_valid, // Sample present.
   output logic [5:0] smp_idx, // Channel.
   output logic [15:0] smp_raw, // Measured count.
   output logic [15:0] smp_base, // Baseline count.
   output logic smp_last // Scan end.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sig [0:42];
   initial begin
      smp_valid = 1'b0;
      smp_idx = 6'h00;
      smp_raw = 16'h0000;
      smp_base = 16'h0000;
      smp_last = 1'b0;
   end
   // Baselines differ per channel, so only raw minus base can give the signal.
   task automatic scan(output bit ok);
      int n;
      ok = 1'b1;
      for (int ch = 0; ch < 43; ch++) begin
         @(negedge mclk);
         smp_valid = 1'b1;
         smp_idx = 6'(ch);
         smp_base = 16'h0400 + 16'(ch);
         smp_raw = smp_base + sig[ch];
         smp_last = (ch == 42);
         n = 0;
         while (!smp_ready && n < 20) begin
            @(negedge mclk);
            n++;
         end
         if (!smp_ready) ok = 1'b0;
         @(posedge mclk);
      end
      @(negedge mclk);
      smp_valid = 1'b0;
      smp_last = 1'b0;
      smp_raw = ~smp_raw;
      smp_base = ~smp_base;
   endtask
endmodule

// File: testbench/tb_touch_widget_position_decoder.sv
// Self-checking bench for the touch widget decoder with a front-end model.
// Assumes results are settled at the falling edge after res_valid rises.
`include "twpd_consts.vh"
module tb_touch_widget_position_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] cfg_fthr = 16'h0032, cfg_noise = 16'h0000, cfg_res = 16'h0064;
   logic [15:0] cfg_pthr = 16'h012c;
   logic cfg_pgang = 1'b0;
   wire smp_valid, smp_ready, smp_last, key_valid, key_invalid, lin_act, dip_act;
   wire rad_act, trk_act, prox_on, res_valid;
   wire [5:0] smp_idx;
   wire [15:0] smp_raw, smp_base, lin_pos, dip_pos, rad_pos, trk_x, trk_y;
   wire [3:0] btn_on, key_idx;
   int err_count = 0, samples_checked = 0, cycles = 0;
   twpd_decoder dut_u (.mclk(mclk), .rstn(rstn), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_idx(smp_idx), .smp_raw(smp_raw), .smp_base(smp_base),
      .smp_last(smp_last), .cfg_fthr(cfg_fthr), .cfg_noise(cfg_noise), .cfg_res(cfg_res),
      .cfg_pthr(cfg_pthr), .cfg_pgang(cfg_pgang), .btn_on(btn_on), .key_valid(key_valid),
      .key_idx(key_idx), .key_invalid(key_invalid), .lin_pos(lin_pos), .lin_act(lin_act),
      .dip_pos(dip_pos), .dip_act(dip_act), .rad_pos(rad_pos), .rad_act(rad_act),
      .trk_x(trk_x), .trk_y(trk_y), .trk_act(trk_act), .prox_on(prox_on),
      .res_valid(res_valid));
   twpd_frontend fe_u (.mclk(mclk), .smp_ready(smp_ready), .smp_valid(smp_valid),
      .smp_idx(smp_idx), .smp_raw(smp_raw), .smp_base(smp_base), .smp_last(smp_last));
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic clear();
      for (int ch = 0; ch < 43; ch++) fe_u.sig[ch] = 16'h0000;
   endtask
   // Peak of 150 on segment 2 with neighbours 100 and 110.
   task automatic lin_pat(input int b);
      fe_u.sig[b + 1] = 16'h0064;
      fe_u.sig[b + 2] = 16'h0096;
      fe_u.sig[b + 3] = 16'h006e;
   endtask
   task automatic run_scan();
      bit ok;
      int n;
      fe_u.scan(ok);
      n = 0;
      while (res_valid !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      if (!ok || n == 20) begin
         err_count++;
         $display("Error scan handshake expected done seen stalled");
      end
   endtask
   task automatic t_basic();
      clear();
      fe_u.sig[0] = 16'h0032;
      fe_u.sig[1] = 16'h0031;
      fe_u.sig[2] = 16'h00c8;
      fe_u.sig[`TWPD_CH_ROW + 1] = 16'h00c8;
      fe_u.sig[`TWPD_CH_COL + 2] = 16'h00c8;
      lin_pat(`TWPD_CH_LIN);
      lin_pat(`TWPD_CH_TX);
      fe_u.sig[`TWPD_CH_TY + 3] = 16'h0064;
      fe_u.sig[`TWPD_CH_TY + 4] = 16'h00c8;
      fe_u.sig[`TWPD_CH_RAD] = 16'h00c8;
      fe_u.sig[`TWPD_CH_RAD + 1] = 16'h0032;
      fe_u.sig[`TWPD_CH_RAD + 7] = 16'h0064;
      fe_u.sig[`TWPD_CH_DIP + 6] = 16'h003c;
      fe_u.sig[`TWPD_CH_DIP + 1] = 16'h0096;
      fe_u.sig[`TWPD_CH_DIP + 4] = 16'h0050;
      fe_u.sig[`TWPD_CH_PRX] = 16'h012c;
      run_scan();
      check("btn_on", 16'h0005, 16'(btn_on));
      check("key_valid", 16'h0001, 16'(key_valid));
      check("key_idx", 16'h0005, 16'(key_idx));
      check("lin_pos", 16'h0033, lin_pos);
      check("lin_act", 16'h0001, 16'(lin_act));
      check("trk_x", 16'h0033, trk_x);
      check("trk_y", 16'h005c, trk_y);
      check("trk_act", 16'h0001, 16'(trk_act));
      check("rad_pos", 16'h0062, rad_pos);
      check("dip_pos", 16'h004a, dip_pos);
      check("prox_on", 16'h0001, 16'(prox_on));
      check("rad_act", 16'h0001, 16'(rad_act));
      check("dip_act", 16'h0001, 16'(dip_act));
   endtask
   task automatic t_reset();
      @(negedge mclk);
      rstn = 1'b0;
      @(negedge mclk);
      check("reset lin_pos", 16'h0000, lin_pos);
      check("reset btn_on", 16'h0000, 16'(btn_on));
      check("reset res_valid", 16'h0000, 16'(res_valid));
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
   endtask
   task automatic t_multi();
      clear();
      cfg_noise = 16'h005a;
      cfg_pgang = 1'b1;
      cfg_pthr = 16'h0064;
      cfg_res = 16'h00c8;
      fe_u.sig[0] = 16'h001e;
      fe_u.sig[1] = 16'h001e;
      fe_u.sig[2] = 16'h0014;
      fe_u.sig[3] = 16'h0014;
      fe_u.sig[`TWPD_CH_ROW] = 16'h00c8;
      fe_u.sig[`TWPD_CH_ROW + 2] = 16'h00c8;
      fe_u.sig[`TWPD_CH_COL + 1] = 16'h00c8;
      lin_pat(`TWPD_CH_LIN);
      run_scan();
      check("key_invalid", 16'h0001, 16'(key_invalid));
      check("key_valid", 16'h0000, 16'(key_valid));
      check("key_idx", 16'h0000, 16'(key_idx));
      check("lin_pos noise", 16'h006a, lin_pos);
      check("btn_on", 16'h0000, 16'(btn_on));
      check("prox_on ganged", 16'h0001, 16'(prox_on));
      check("dip_act", 16'h0000, 16'(dip_act));
      check("trk_act", 16'h0000, 16'(trk_act));
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
      t_basic();
      t_reset();
      t_multi();
      stop_test();
   end
endmodule
